// ===== logic/motion_aux_defs.svh
/*
   Constants for the auxiliary axis functions: queue geometry, sense-bit layout,
   reset values and output timing.
   Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef MOTION_AUX_DEFS_SVH
`define MOTION_AUX_DEFS_SVH

`define QUEUE_DEPTH      8
`define QUEUE_PTR_W      3
`define QUEUE_CNT_W      4
`define AXES             4
`define CNT_W            16
`define PW_W             8
`define SENSE_W          9
`define SENSE_PLUS_LSB   0
`define SENSE_MINUS_LSB  4
`define SENSE_HALT_BIT   8
`define SENSE_RESET      9'h000
`define MOTION_AXIS      0
// gp output pulse width default: 1 us at 40 MHz
`define PW_TIME_NS       1000
`define CLK_PERIOD_NS    25
`define PW_RESET         8'(`PW_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== logic/motion_aux_pkg.sv
/*
   Types shared by the auxiliary axis functions.
   Assumes motion_aux_defs.svh is on the include path.
*/
`include "motion_aux_defs.svh"

package motion_aux_pkg;

   typedef enum logic [1:0] {kind_general, kind_special, kind_counter} cmd_kind_t;

   typedef struct packed {
      cmd_kind_t           kind;
      logic                dir;     // 1 = plus direction
      logic [`CNT_W-1:0]   count;   // pulse count, or preset value for counter commands
   } cmd_t;

   typedef enum logic {st_idle, st_run} axis_state_t;

endpackage : motion_aux_pkg

// ===== logic/motion_axis_aux_functions.sv
/*
   Auxiliary axis functions: reservation queue launch, soft travel boundary,
   triangle avoidance, limit sense selection, batch gp I/O and step-out stop.
   Assumes all inputs synchronous to clk; pulse generation drives axis 0 only.
*/
`timescale 1ns/10ps
`include "motion_aux_defs.svh"

// Functional notes
// - Axis 0 keeps up to eight waiting drive commands besides the running one.
// - Waiting commands leave in the order they were written.
// - When a move ends the oldest waiting command starts on its own until none are left, except while stepout_err is set.
// - Only general drive commands may wait; special and counter commands run at once only.
// - A soft travel boundary can be set inside the switch-limited range.
// - With the boundary on, the axis slows by itself and stops exactly at it.
// - In ramped moves the profile can be reshaped so the speed curve is not a triangle.
// - Software can flip each limit input between normally-closed and normally-open sense.
// - Four gp inputs and four gp outputs are read or written together in one access.
// - Loss of step of an open-loop stepper is detected and reported as an error.
// - On step-out the pulses stop at once and stepout_err shows the error.
// - Gp outputs can be latched or given a set pulse width per assertion.
// - With the boundary off, a speed change may exceed top speed or drop below start speed.
// - After reset all travel switches and the emergency halt use normally-closed sense.
module motion_axis_aux_functions (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        ce,
   input  wire logic                        cmd_valid,
   input  wire logic                        cmd_reserve,
   input  wire motion_aux_pkg::cmd_t        cmd_in,
   input  wire logic [`CNT_W-1:0]           start_period,
   input  wire logic [`CNT_W-1:0]           top_period,
   input  wire logic                        speed_chg,
   input  wire logic [`CNT_W-1:0]           speed_period,
   input  wire logic                        soft_en,
   input  wire logic signed [`CNT_W-1:0]    soft_plus,
   input  wire logic signed [`CNT_W-1:0]    soft_minus,
   input  wire logic                        avoid_en,
   input  wire logic                        sense_we,
   input  wire logic [`SENSE_W-1:0]         sense_wdata,
   input  wire logic [`AXES-1:0]            plus_travel_switch,
   input  wire logic [`AXES-1:0]            minus_travel_switch,
   input  wire logic                        emergency_halt_input,
   input  wire logic [`AXES-1:0]            axis_gp_input,
   input  wire logic                        gp_we,
   input  wire logic [`AXES-1:0]            gp_wdata,
   input  wire logic                        gp_latch_en,
   input  wire logic [`PW_W-1:0]            gp_pw,
   input  wire logic                        driver_alarm_input,
   input  wire logic                        alarm_en,
   input  wire logic                        err_clr,
   output logic                             plus_pulse_output,
   output logic                             minus_pulse_output,
   output logic                             busy,
   output logic                             cmd_rejected,
   output logic [`QUEUE_CNT_W-1:0]          queue_level,
   output logic signed [`CNT_W-1:0]         position,
   output logic [`SENSE_W-1:0]              limit_state,
   output logic [`AXES-1:0]                 gp_in_state,
   output logic [`AXES-1:0]                 axis_gp_output,
   output logic                             stepout_err
);
   import motion_aux_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   queue_if q ();
   reserve_queue u_queue (.clk(clk), .rst(rst), .ce(ce), .q(q.store));

   axis_state_t              state_ff;
   logic                     dir_ff;
   logic [`CNT_W-1:0]        rem_ff;
   logic [`CNT_W-1:0]        cur_ff;
   logic [`CNT_W-1:0]        top_eff_ff;
   logic [`CNT_W-1:0]        ramp_ff;
   logic [`CNT_W-1:0]        per_cnt_ff;
   logic signed [`CNT_W-1:0] pos_ff;
   logic [`SENSE_W-1:0]      sense_ff;
   logic [`QUEUE_CNT_W-1:0]  level_ff;
   logic                     plus_ff;
   logic                     minus_ff;
   logic                     reject_ff;
   logic                     err_ff;

   // limit sense: active when the input disagrees with its closed level
   wire [`SENSE_W-1:0] sw_raw = {emergency_halt_input, minus_travel_switch, plus_travel_switch};
   wire [`SENSE_W-1:0] lim_act = ~(sw_raw ^ sense_ff);
   wire                halt_act  = lim_act[`SENSE_HALT_BIT];
   wire                plus_act  = lim_act[`SENSE_PLUS_LSB + `MOTION_AXIS];
   wire                minus_act = lim_act[`SENSE_MINUS_LSB + `MOTION_AXIS];

   // command acceptance
   wire idle      = (state_ff == st_idle);
   wire imm       = cmd_valid && !cmd_reserve;
   wire res       = cmd_valid && cmd_reserve;
   wire is_gen    = (cmd_in.kind == kind_general);
   wire is_cnt    = (cmd_in.kind == kind_counter);
   wire res_ok    = res && is_gen && !q.full;
   wire imm_ok    = imm && idle && !err_ff;
   wire start_imm = imm_ok && !is_cnt;
   wire preset    = imm_ok && is_cnt;
   wire pop_q     = idle && !err_ff && !imm && !q.empty;
   wire start_any = start_imm || pop_q;
   cmd_t start_cmd;
   assign start_cmd = start_imm ? cmd_in : q.rdata;
   assign q.push    = res_ok;
   assign q.pop     = pop_q;
   assign q.wdata   = cmd_in;

   // soft boundary distance, clipped at zero so an axis already at it never steps
   wire signed [`CNT_W:0] d_plus  = {soft_plus[`CNT_W-1], soft_plus} - {pos_ff[`CNT_W-1], pos_ff};
   wire signed [`CNT_W:0] d_minus = {pos_ff[`CNT_W-1], pos_ff} - {soft_minus[`CNT_W-1], soft_minus};
   wire signed [`CNT_W:0] d_raw   = dir_ff ? d_plus : d_minus;
   wire [`CNT_W-1:0]      d_left  = d_raw[`CNT_W] ? '0 : d_raw[`CNT_W-1:0];
   wire [`CNT_W-1:0]      rem_eff = (soft_en && d_left < rem_ff) ? d_left : rem_ff;

   // step-out detection from the driver alarm while moving
   wire alarm_hit  = alarm_en && driver_alarm_input && !idle;
   wire stop_hard  = halt_act || (dir_ff ? plus_act : minus_act) || alarm_hit || err_ff;
   wire run_done   = !idle && (rem_eff == '0 || stop_hard);
   wire step       = !idle && per_cnt_ff == '0 && rem_eff != '0 && !stop_hard;

   // profile: decelerate once the remaining distance equals the ramp built up
   wire [`CNT_W+1:0] ramp3 = {2'b00, ramp_ff} + {1'b0, ramp_ff, 1'b0};
   wire decel  = rem_eff <= ramp_ff;
   wire tri_cap = avoid_en && ramp3 >= {2'b00, rem_eff};
   wire accel  = !decel && !tri_cap && cur_ff > top_eff_ff;
   wire [`CNT_W-1:0] nxt_cur =
      (decel && cur_ff < start_period) ? cur_ff + 1'b1 :
      accel                            ? cur_ff - 1'b1 :
      (!decel && cur_ff < top_eff_ff)  ? cur_ff + 1'b1 : cur_ff;
   wire [`CNT_W-1:0] nxt_ramp =
      accel ? ramp_ff + 1'b1 : (decel && ramp_ff != '0) ? ramp_ff - 1'b1 : ramp_ff;

   // speed change: clamped to the profile range only while the boundary is on
   wire [`CNT_W-1:0] spd_lo  = (speed_period < top_period) ? top_period : speed_period;
   wire [`CNT_W-1:0] spd_cl  = (spd_lo > start_period) ? start_period : spd_lo;
   wire [`CNT_W-1:0] spd_tgt = soft_en ? spd_cl : speed_period;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= st_idle;
      end else if (ce) begin
         state_ff <= start_any ? st_run : (run_done ? st_idle : state_ff);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dir_ff     <= 1'b0;
         rem_ff     <= '0;
         cur_ff     <= '0;
         top_eff_ff <= '0;
         ramp_ff    <= '0;
         per_cnt_ff <= '0;
      end else if (ce) begin
         if (start_any) begin
            dir_ff     <= start_cmd.dir;
            rem_ff     <= start_cmd.count;
            cur_ff     <= start_period;
            top_eff_ff <= top_period;
            ramp_ff    <= '0;
            per_cnt_ff <= start_period;
         end else begin
            if (speed_chg && !idle) begin
               top_eff_ff <= spd_tgt;
            end
            if (step) begin
               rem_ff     <= rem_ff - 1'b1;
               cur_ff     <= nxt_cur;
               ramp_ff    <= nxt_ramp;
               per_cnt_ff <= nxt_cur;
            end else if (per_cnt_ff != '0) begin
               per_cnt_ff <= per_cnt_ff - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos_ff    <= '0;
         plus_ff   <= 1'b0;
         minus_ff  <= 1'b0;
         reject_ff <= 1'b0;
         err_ff    <= 1'b0;
         sense_ff  <= `SENSE_RESET;
         level_ff  <= '0;
      end else if (ce) begin
         pos_ff    <= preset ? signed'(cmd_in.count) :
                      step ? (dir_ff ? pos_ff + 1'b1 : pos_ff - 1'b1) : pos_ff;
         plus_ff   <= step && dir_ff;
         minus_ff  <= step && !dir_ff;
         reject_ff <= (res && !res_ok) || (imm && !imm_ok);
         err_ff    <= alarm_hit || (err_ff && !err_clr);       // set wins over clear
         if (sense_we) begin
            sense_ff <= sense_wdata;
         end
         level_ff  <= q.level + `QUEUE_CNT_W'(res_ok) - `QUEUE_CNT_W'(pop_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gp outputs: pulse width of zero behaves as latched
   logic [`AXES-1:0] gp_out_ff;
   logic [`AXES-1:0] gp_in_ff;
   logic [`SENSE_W-1:0] lim_ff;
   generate
      for (genvar i = 0; i < `AXES; i++) begin : g_gp
         logic [`PW_W-1:0] pw_cnt_ff;
         wire timed = !gp_latch_en && pw_cnt_ff != '0;
         always_ff @(posedge clk) begin
            if (rst) begin
               gp_out_ff[i] <= 1'b0;
               pw_cnt_ff    <= '0;
            end else if (ce) begin
               if (gp_we) begin
                  gp_out_ff[i] <= gp_wdata[i];
                  pw_cnt_ff    <= gp_wdata[i] ? gp_pw : '0;
               end else if (timed) begin
                  pw_cnt_ff    <= pw_cnt_ff - 1'b1;
                  gp_out_ff[i] <= (pw_cnt_ff != `PW_W'(1)) && gp_out_ff[i];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         gp_in_ff <= '0;
         lim_ff   <= '0;
      end else if (ce) begin
         gp_in_ff <= axis_gp_input;
         lim_ff   <= lim_act;
      end
   end

   assign plus_pulse_output  = plus_ff;
   assign minus_pulse_output = minus_ff;
   assign busy               = (state_ff == st_run);
   assign cmd_rejected       = reject_ff;
   assign queue_level        = level_ff;
   assign position           = pos_ff;
   assign limit_state        = lim_ff;
   assign gp_in_state        = gp_in_ff;
   assign axis_gp_output     = gp_out_ff;
   assign stepout_err        = err_ff;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   // an idle axis may pop in the same cycle, so only that pop may move the level
   queue_kind_a: assert property (res && !is_gen |=> cmd_rejected &&
                  q.level == $past(q.level) - `QUEUE_CNT_W'($past(pop_q)))
      else $error("non-general command entered the queue");
   full_reject_a: assert property (res && q.full && !pop_q |=> cmd_rejected)
      else $error("reservation to full queue not flagged");
   auto_launch_a: assert property (idle && !err_ff && !cmd_valid && !q.empty |=> busy)
      else $error("queued command not launched");
   soft_stop_a: assert property (soft_en && busy && dir_ff && pos_ff == soft_plus |-> !step)
      else $error("axis stepped past soft boundary");
   stepout_halt_a: assert property (alarm_hit |=> stepout_err ##1 !plus_pulse_output && !minus_pulse_output)
      else $error("pulses continued after step-out");
   limit_sense_a: assert property (!sense_ff[0] && plus_travel_switch[0] |=> !limit_state[0])
      else $error("closed switch reported active");
   sense_reset_a: assert property ($fell(rst) |-> sense_ff == `SENSE_RESET)
      else $error("limit sense not normally-closed after reset");
   gp_pulse_a: assert property (gp_we && !gp_latch_en && gp_wdata[0] && gp_pw == `PW_W'(2)
                  ##1 (!gp_we && ce) [*3] |-> !axis_gp_output[0])
      else $error("gp output pulse width wrong");
   batch_read_a: assert property (1'b1 |=> gp_in_state == $past(axis_gp_input))
      else $error("gp inputs not captured together");

   queue_launch_c: cover property (pop_q ##1 busy);
   full_reject_c:  cover property (res && q.full);
   soft_stop_c:    cover property (soft_en && busy && d_left == '0);
   stepout_c:      cover property (alarm_hit);

endmodule : motion_axis_aux_functions

// ===== logic/queue_if.sv
/*
   Carrier between the axis controller and its reservation queue.
   Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`include "motion_aux_defs.svh"

interface queue_if;
   import motion_aux_pkg::*;
   logic                    push;
   logic                    pop;
   cmd_t                    wdata;
   cmd_t                    rdata;
   logic                    full;
   logic                    empty;
   logic [`QUEUE_CNT_W-1:0] level;

   modport user  (output push, output pop, output wdata,
                  input rdata, input full, input empty, input level);
   modport store (input push, input pop, input wdata,
                  output rdata, output full, output empty, output level);
endinterface : queue_if

// ===== logic/reserve_queue.sv
/*
   Eight-entry first-in first-out store for reserved drive commands.
   Assumes the user never pushes when full nor pops when empty; both are ignored here anyway.
*/
`timescale 1ns/10ps
`include "motion_aux_defs.svh"

module reserve_queue (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   queue_if.store    q
);
   import motion_aux_pkg::*;

   cmd_t                    mem [`QUEUE_DEPTH];
   logic [`QUEUE_PTR_W-1:0] wr_ptr_ff;
   logic [`QUEUE_PTR_W-1:0] rd_ptr_ff;
   logic [`QUEUE_CNT_W-1:0] level_ff;
   wire                     do_push = q.push && !q.full;
   wire                     do_pop  = q.pop && !q.empty;

   assign q.full  = (level_ff == `QUEUE_CNT_W'(`QUEUE_DEPTH));
   assign q.empty = (level_ff == '0);
   assign q.rdata = mem[rd_ptr_ff];   // oldest entry leaves first
   assign q.level = level_ff;

   always_ff @(posedge clk) begin
      if (ce && do_push) begin
         mem[wr_ptr_ff] <= q.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff  <= '0;
      end else if (ce) begin
         wr_ptr_ff <= wr_ptr_ff + `QUEUE_PTR_W'(do_push);
         rd_ptr_ff <= rd_ptr_ff + `QUEUE_PTR_W'(do_pop);
         level_ff  <= level_ff + `QUEUE_CNT_W'(do_push) - `QUEUE_CNT_W'(do_pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   queue_bound_a: assert property (level_ff <= `QUEUE_CNT_W'(`QUEUE_DEPTH))
      else $error("queue level above depth");
   queue_order_a: assert property (do_push && q.empty && !do_pop |=> q.rdata == $past(q.wdata))
      else $error("first pushed entry is not at the head");

endmodule : reserve_queue

// ===== testbench/motor_stand_in.sv
/*
   Stand-in for the axis 0 motor driver: counts steps, keeps the last eight
   step directions, raises the driver alarm on request.
   Assumes one-cycle step pulses synchronous to clk.
*/
`timescale 1ns/10ps

module motor_stand_in (
   input  wire logic clk,
   input  wire logic plus_step,
   input  wire logic minus_step,
   input  wire logic fault,
   output logic      alarm,
   output logic [15:0] steps_ff,
   output logic [7:0]  dirs_ff
);
   logic [15:0] cnt_ff  = 16'h0;
   logic [7:0]  hist_ff = 8'h0;
   // a stalled open-loop motor keeps reporting until freed
   assign alarm    = fault;
   assign steps_ff = cnt_ff;
   assign dirs_ff  = hist_ff;
   always @(posedge clk) begin
      if (plus_step || minus_step) begin
         cnt_ff  <= cnt_ff + 16'h1;
         hist_ff <= {hist_ff[6:0], plus_step};
      end
   end
endmodule : motor_stand_in

// ===== testbench/test_motion_axis_aux_functions.sv
/*
   Self-checking bench for the auxiliary axis functions.
   Assumes the design files and motor_stand_in are compiled first.
*/
`timescale 1ns/10ps
`include "motion_aux_defs.svh"

module test_motion_axis_aux_functions;
   import motion_aux_pkg::*;
   logic clk = 0, rst = 1, ce = 1, cmd_valid = 0, cmd_reserve = 0;
   cmd_t cmd_in = '0;
   logic soft_en = 0, sense_we = 0, halt = 1, gp_we = 0, latch = 0, alarm_en = 0;
   logic err_clr = 0, fault = 0, alarm, busy, rejected, stepout_err, pls, mns;
   logic avoid = 0, spd_chg = 0;
   logic [15:0] spd_period = 16'h0003;
   logic signed [15:0] soft_plus = 16'h0, soft_minus = 16'h0, position;
   logic [8:0]  sense_wdata = 9'h0, limit_state;
   logic [3:0]  plus_sw = 4'hf, minus_sw = 4'hf, gp_in = 4'h0, gp_wdata = 4'h0;
   logic [3:0]  queue_level, gp_in_state, gp_out;
   logic [7:0]  gp_pw = 8'h0, dirs;
   logic [15:0] steps;
   int fails = 0, check_count = 0, cycles = 0;

   always #12.5 clk = ~clk;

   motion_axis_aux_functions i_motion_axis_aux_functions (
      .clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd_reserve(cmd_reserve),
      .cmd_in(cmd_in), .start_period(16'h0004), .top_period(16'h0002), .speed_chg(spd_chg),
      .speed_period(spd_period), .soft_en(soft_en), .soft_plus(soft_plus),
      .soft_minus(soft_minus), .avoid_en(avoid), .sense_we(sense_we),
      .sense_wdata(sense_wdata), .plus_travel_switch(plus_sw), .minus_travel_switch(minus_sw),
      .emergency_halt_input(halt), .axis_gp_input(gp_in), .gp_we(gp_we),
      .gp_wdata(gp_wdata), .gp_latch_en(latch), .gp_pw(gp_pw), .driver_alarm_input(alarm),
      .alarm_en(alarm_en), .err_clr(err_clr), .plus_pulse_output(pls),
      .minus_pulse_output(mns), .busy(busy), .cmd_rejected(rejected),
      .queue_level(queue_level), .position(position), .limit_state(limit_state),
      .gp_in_state(gp_in_state), .axis_gp_output(gp_out), .stepout_err(stepout_err));

   motor_stand_in i_motor_stand_in (.clk(clk), .plus_step(pls), .minus_step(mns),
      .fault(fault), .alarm(alarm), .steps_ff(steps), .dirs_ff(dirs));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   // valid stays high so callers can issue back to back
   task automatic put(input cmd_kind_t k, input logic r, input logic d, input logic [15:0] n);
      @(posedge clk);
      cmd_valid   <= 1'b1;
      cmd_reserve <= r;
      cmd_in      <= '{kind: k, dir: d, count: n};
   endtask : put

   task automatic one(input cmd_kind_t k, input logic d, input logic [15:0] n);
      put(k, 1'b0, d, n);
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
   endtask : one

   // queued moves leave a one-cycle busy gap, so demand several quiet cycles
   task automatic wait_idle;
      int q = 0;
      for (int i = 0; i < 3000 && q < 4; i++) begin
         @(negedge clk);
         q = (busy === 1'b0 && queue_level === 4'h0) ? q + 1 : 0;
      end
      chk("idle", q, 4);
   endtask : wait_idle

   task automatic set_sense(input logic [8:0] v);
      @(posedge clk);
      sense_we    <= 1'b1;
      sense_wdata <= v;
      @(posedge clk);
      sense_we <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : set_sense

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_sense;
      chk("limits idle", limit_state, 9'h000);
      @(posedge clk);
      minus_sw <= 4'hd;
      halt     <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("limits open", limit_state, 9'h120);
      one(kind_general, 1'b1, 16'h2);
      wait_idle();
      chk("halted steps", steps, 0);
      set_sense(9'h020);
      chk("limits flipped", limit_state, 9'h100);
      @(posedge clk);
      minus_sw <= 4'hf;
      halt     <= 1'b1;
      set_sense(9'h000);
      chk("limits restored", limit_state, 9'h000);
   endtask : t_sense

   task automatic t_gpio;
      @(posedge clk);
      gp_in    <= 4'h5;
      gp_we    <= 1'b1;
      gp_wdata <= 4'hb;
      gp_pw    <= 8'h02;
      @(posedge clk);
      gp_we <= 1'b0;
      @(negedge clk);
      chk("gp in", gp_in_state, 4'h5);
      chk("gp out 1", gp_out, 4'hb);
      @(negedge clk);
      chk("gp out 2", gp_out, 4'hb);
      @(negedge clk);
      chk("gp out 3", gp_out, 4'h0);
      @(posedge clk);
      gp_we    <= 1'b1;
      gp_wdata <= 4'h3;
      latch    <= 1'b1;
      @(posedge clk);
      gp_we <= 1'b0;
      repeat (5) @(negedge clk);
      chk("gp latched", gp_out, 4'h3);
   endtask : t_gpio

   task automatic chk_q(input int j);
      @(negedge clk);
      chk("rejected", rejected, j == 1 || j == 2 || j == 11);
      chk("level", queue_level, j < 3 ? 0 : (j > 10 ? 8 : j - 2));
      if (j == 0) chk("busy", busy, 1);
   endtask : chk_q

   task automatic t_queue;
      logic [7:0] p = 8'hb2;
      one(kind_counter, 1'b0, 16'd100);
      chk("preset", position, 100);
      for (int k = 0; k < 12; k++) begin
         if (k == 0) put(kind_general, 1'b0, 1'b1, 16'd12);
         else if (k == 1) put(kind_special, 1'b1, 1'b1, 16'd5);
         else if (k == 2) put(kind_counter, 1'b1, 1'b0, 16'd7);
         else put(kind_general, 1'b1, (k < 11) ? p[10-k] : 1'b1, 16'd1);
         if (k > 0) chk_q(k - 1);
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      chk_q(11);
      wait_idle();
      chk("queue end", position, 112);
      chk("queue order", dirs, p);
   endtask : t_queue

   task automatic t_soft;
      logic [15:0] s;
      one(kind_counter, 1'b0, 16'd0);
      s = steps;
      soft_plus  <= 16'sd5;
      soft_minus <= -16'sd5;
      soft_en    <= 1'b1;
      one(kind_general, 1'b1, 16'd20);
      wait_idle();
      chk("soft plus", position, 5);
      one(kind_general, 1'b0, 16'd20);
      wait_idle();
      chk("soft minus", position, -5);
      chk("soft steps", steps - s, 15);
      soft_en <= 1'b0;
   endtask : t_soft

   task automatic t_stepout;
      logic [15:0] s;
      alarm_en <= 1'b1;
      one(kind_general, 1'b1, 16'd40);
      for (int i = 0; i < 300 && position < -16'sd2; i++) @(posedge clk);
      fault <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("stepout", stepout_err, 1);
      chk("stepout busy", busy, 0);
      s = steps;
      one(kind_general, 1'b1, 16'd4);
      chk("blocked launch", rejected, 1);
      repeat (20) @(negedge clk);
      chk("no pulses", steps, s);
      @(posedge clk);
      fault   <= 1'b0;
      err_clr <= 1'b1;
      @(posedge clk);
      err_clr <= 1'b0;
      @(negedge clk);
      chk("cleared", stepout_err, 0);
   endtask : t_stepout

   // shortest pulse spacing of one plus move: the running period plus one cycle
   task automatic t_profile(input logic av, input logic se, input logic ch,
                            input logic [15:0] sp, input logic [15:0] n, input int gap);
      int g = 0;
      int m = 99;
      avoid      <= av;
      soft_en    <= se;
      soft_plus  <= 16'sh7fff;
      soft_minus <= -16'sh7fff;
      spd_period <= sp;
      one(kind_general, 1'b1, n);
      @(posedge clk);
      spd_chg <= ch;
      @(posedge clk);
      spd_chg <= 1'b0;
      for (int i = 0; i < 400 && busy === 1'b1; i++) begin
         @(negedge clk);
         g++;
         if (pls === 1'b1) begin
            m = (g < m) ? g : m;
            g = 0;
         end
      end
      chk("min gap", m, gap);
   endtask : t_profile

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_sense();
      t_gpio();
      t_queue();
      t_soft();
      t_stepout();
      t_profile(1'b0, 1'b0, 1'b0, 16'h0003, 16'd4, 3);
      t_profile(1'b1, 1'b0, 1'b0, 16'h0003, 16'd4, 4);
      t_profile(1'b0, 1'b0, 1'b1, 16'h0001, 16'd20, 2);
      t_profile(1'b0, 1'b1, 1'b1, 16'h0001, 16'd20, 3);
      give_verdict();
   end
endmodule : test_motion_axis_aux_functions
